// ===== src/cstc_charge_ctrl.sv
// Purpose: Fast/trickle charge state supervisor with strap decode and timers
// Assumes: Flags and straps are asynchronous pins; analog divide and compare done outside
// Notes: Timer and sample periods in minutes/seconds become cycle parameters
//
// Summary of operation
// - Always exactly one of two states, fast or trickle.
// - While power-on hold is low, keep trickle.
// - On hold release, go fast only if per-cell voltage above lockout.
// - Negative slope during fast returns to trickle.
// - Cold keeps trickle; fast starts when temperature enters safe window.
// - Hot during fast reverts to trickle.
// - Slope, temperature or timeout each end fast charge.
// - Cell count is four times major index plus minor index plus one.
// - Range strap selects timeout pair and sampling interval.
// - Length strap picks short/long timeout and slope enable.
// - Slope input is battery voltage over programmed cell count.
// - Out-of-window converter input disables slope termination.
// - Longest selectable timeout is 264 minutes.
// - Timeout or slope detection forces trickle over every other flag.
// - Hot at power-up blocks fast until cooled and supply cycled.
// - Status output sinks throughout fast, released in trickle.
`timescale 1ns/10ps
module cstc_charge_ctrl #(
  parameter longint unsigned SAMPLE_CYCLES =
    longint'(cstc_pkg::CSTC_SAMPLE_SEC) * cstc_pkg::CSTC_CLK_HZ,
  parameter longint unsigned MINUTE_CYCLES =
    longint'(cstc_pkg::CSTC_SEC_PER_MIN) * cstc_pkg::CSTC_CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps and analog flags
  input wire cstc_pkg::cstc_straps_t straps,
  input wire cstc_pkg::cstc_flags_t flags,
  // Status
  output logic fast_state_status_out_oe_n,
  output logic fast_state,
  output cstc_pkg::cstc_config_t config_out,
  output logic timer_expired,
  output logic slope_detected
);

  // Elaboration checks
  if (SAMPLE_CYCLES < 1 || MINUTE_CYCLES < 1) begin : g_cycles_chk
    $error("cycle counts must be at least one");
  end
  if (cstc_pkg::CSTC_TMO_LONG_TBL[35:27] != 9'(cstc_pkg::CSTC_TMO_MAX_MIN)) begin : g_table_chk
    $error("timeout table inconsistent");
  end

  // Two-flop synchronisers
  localparam int FW = $bits(cstc_pkg::cstc_flags_t);
  localparam int SW = $bits(cstc_pkg::cstc_straps_t);
  logic [FW-1:0] flag_s1_reg, flag_s2_reg;
  logic [SW-1:0] strap_s1_reg, strap_s2_reg;
  cstc_pkg::cstc_flags_t f;
  cstc_pkg::cstc_straps_t st;

  always_ff @(posedge clk) begin
    flag_s1_reg <= flags;
    flag_s2_reg <= flag_s1_reg;
    strap_s1_reg <= straps;
    strap_s2_reg <= strap_s1_reg;
  end
  assign f = cstc_pkg::cstc_flags_t'(flag_s2_reg);
  assign st = cstc_pkg::cstc_straps_t'(strap_s2_reg);

  // State
  cstc_pkg::cstc_state_t state_reg, state_next;
  cstc_pkg::cstc_config_t cfg_reg, cfg_next;
  logic hold_d_reg, hold_d_next;
  logic hot_lock_reg, hot_lock_next;
  logic cold_arm_reg, cold_arm_next;
  logic [63:0] min_cnt_reg, min_cnt_next;
  logic [8:0] min_elapsed_reg, min_elapsed_next;
  logic [63:0] smp_cnt_reg, smp_cnt_next;
  logic [3:0] smp_mult_reg, smp_mult_next;
  logic slope_det_reg, slope_det_next;
  logic [8:0] timeout_min;
  logic [3:0] smp_div;
  logic hold_rise, expired, sample_tick;

  // Table lookup; short column is not a clean doubling (45 not 44)
  always_comb begin
    timeout_min = cfg_reg.long_timeout ?
      cstc_pkg::CSTC_TMO_LONG_TBL[9 * cfg_reg.range_idx +: 9] :
      cstc_pkg::CSTC_TMO_SHORT_TBL[9 * cfg_reg.range_idx +: 9];
    smp_div = 4'(4'h1 << cfg_reg.range_idx);
  end

  assign hold_rise = f.power_on_hold_n && !hold_d_reg;
  assign expired = (min_elapsed_reg >= timeout_min);
  assign sample_tick = (smp_cnt_reg == SAMPLE_CYCLES - 1) && (smp_mult_reg == smp_div - 4'h1);

  always_comb begin
    cfg_next = cfg_reg;
    hold_d_next = f.power_on_hold_n;
    hot_lock_next = hot_lock_reg;
    cold_arm_next = cold_arm_reg;
    state_next = state_reg;
    // Straps latched only while hold is low, static afterwards
    if (!f.power_on_hold_n) begin
      cfg_next.cell_count = 5'({st.cell_count_strap_major, 2'h0}) +
        5'(st.cell_count_strap_minor) + cstc_pkg::CSTC_CELLS_MIN;
      cfg_next.range_idx = st.timeout_range_strap;
      unique case (st.timeout_length_strap)
        cstc_pkg::CSTC_STRAP_OPEN: begin
          cfg_next.long_timeout = 1'b0;
          cfg_next.slope_enable = 1'b0;
        end
        cstc_pkg::CSTC_STRAP_MID: begin
          cfg_next.long_timeout = 1'b0;
          cfg_next.slope_enable = 1'b1;
        end
        cstc_pkg::CSTC_STRAP_HIGH: begin
          cfg_next.long_timeout = 1'b1;
          cfg_next.slope_enable = 1'b0;
        end
        cstc_pkg::CSTC_STRAP_LOW: begin
          cfg_next.long_timeout = 1'b1;
          cfg_next.slope_enable = 1'b1;
        end
      endcase
    end
    if (!f.power_on_hold_n) begin
      state_next = cstc_pkg::CSTC_TRICKLE;
      hot_lock_next = 1'b0;
      cold_arm_next = 1'b0;
    end else begin
      if (hold_rise && f.hot) begin
        hot_lock_next = 1'b1;
      end
      if (hold_rise && f.cold) begin
        cold_arm_next = 1'b1;
      end
      unique case (state_reg)
        cstc_pkg::CSTC_TRICKLE: begin
          // Fast only on release, or first warm-up after a cold start
          if ((hold_rise || (cold_arm_reg && !f.cold)) && f.cell_above_lockout &&
              !f.cold && !f.hot && !hot_lock_reg && !(hold_rise && f.hot)) begin
            state_next = cstc_pkg::CSTC_FAST;
            cold_arm_next = 1'b0;
          end
        end
        cstc_pkg::CSTC_FAST: begin
          if (expired || slope_det_reg || f.hot || !f.cell_above_lockout) begin
            state_next = cstc_pkg::CSTC_TRICKLE;
          end
        end
      endcase
    end
  end

  // Timeout and sampling counters
  always_comb begin
    min_cnt_next = min_cnt_reg;
    min_elapsed_next = min_elapsed_reg;
    smp_cnt_next = smp_cnt_reg;
    smp_mult_next = smp_mult_reg;
    slope_det_next = slope_det_reg;
    if (state_reg != cstc_pkg::CSTC_FAST) begin
      min_cnt_next = 64'h0;
      min_elapsed_next = 9'h000;
      smp_cnt_next = 64'h0;
      smp_mult_next = 4'h0;
      slope_det_next = 1'b0;
    end else begin
      if (min_cnt_reg == MINUTE_CYCLES - 1) begin
        min_cnt_next = 64'h0;
        if (!expired) begin
          min_elapsed_next = min_elapsed_reg + 9'h001;
        end
      end else begin
        min_cnt_next = min_cnt_reg + 64'h1;
      end
      if (smp_cnt_reg == SAMPLE_CYCLES - 1) begin
        smp_cnt_next = 64'h0;
        smp_mult_next = sample_tick ? 4'h0 : smp_mult_reg + 4'h1;
      end else begin
        smp_cnt_next = smp_cnt_reg + 64'h1;
      end
      // Per-cell value is divided outside; window flag gates it
      if (sample_tick && cfg_reg.slope_enable && f.adc_in_window && f.slope_negative) begin
        slope_det_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= cstc_pkg::CSTC_TRICKLE;
      cfg_reg <= '0;
      hold_d_reg <= 1'b0;
      hot_lock_reg <= 1'b0;
      cold_arm_reg <= 1'b0;
      min_cnt_reg <= 64'h0;
      min_elapsed_reg <= 9'h000;
      smp_cnt_reg <= 64'h0;
      smp_mult_reg <= 4'h0;
      slope_det_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      hold_d_reg <= hold_d_next;
      hot_lock_reg <= hot_lock_next;
      cold_arm_reg <= cold_arm_next;
      min_cnt_reg <= min_cnt_next;
      min_elapsed_reg <= min_elapsed_next;
      smp_cnt_reg <= smp_cnt_next;
      smp_mult_reg <= smp_mult_next;
      slope_det_reg <= slope_det_next;
    end
  end

  assign fast_state = (state_reg == cstc_pkg::CSTC_FAST);
  assign fast_state_status_out_oe_n = !fast_state;
  assign config_out = cfg_reg;
  assign timer_expired = expired && fast_state;
  assign slope_detected = slope_det_reg;

endmodule // cstc_charge_ctrl

// ===== src/cstc_pkg.sv
// Purpose: Shared constants and carrier types for the charge state timer control
// Assumes: 250 MHz system clock
// Notes: Strap index 0..3 = high level, open, mid level, low level
package cstc_pkg;

  localparam int unsigned CSTC_CLK_HZ = 250_000_000;
  localparam int unsigned CSTC_SEC_PER_MIN = 60;

  // Shortest timeout and sampling interval; longer ones are doublings, except the short timeout step to 45 (not 44)
  localparam int unsigned CSTC_TMO_SHORT_MIN = 22;
  localparam int unsigned CSTC_TMO_LONG_MIN = 33;
  localparam int unsigned CSTC_TMO_MAX_MIN = 264;
  localparam int unsigned CSTC_SAMPLE_SEC = 21;
  localparam int unsigned CSTC_SAMPLE_MAX_SEC = 168;

  // Timeout minutes by range index, nine bits per entry, index 0 lowest
  localparam logic [35:0] CSTC_TMO_SHORT_TBL = {9'h0B4, 9'h05A, 9'h02D, 9'h016};
  localparam logic [35:0] CSTC_TMO_LONG_TBL = {9'h108, 9'h084, 9'h042, 9'h021};

  // Cell count span
  localparam logic [4:0] CSTC_CELLS_MIN = 5'h01;
  localparam logic [4:0] CSTC_CELLS_MAX = 5'h10;

  // Strap codes
  localparam logic [1:0] CSTC_STRAP_HIGH = 2'h0;
  localparam logic [1:0] CSTC_STRAP_OPEN = 2'h1;
  localparam logic [1:0] CSTC_STRAP_MID = 2'h2;
  localparam logic [1:0] CSTC_STRAP_LOW = 2'h3;

  // Reset values
  localparam logic [1:0] CSTC_STRAP_RST = 2'h0;

  typedef enum {
    CSTC_TRICKLE,
    CSTC_FAST
  } cstc_state_t;

  // Four strap pins as presented to the block
  typedef struct packed {
    logic [1:0] cell_count_strap_major;
    logic [1:0] cell_count_strap_minor;
    logic [1:0] timeout_length_strap;
    logic [1:0] timeout_range_strap;
  } cstc_straps_t;

  // Comparator and detector flags from the analog side
  typedef struct packed {
    logic power_on_hold_n;
    logic cell_above_lockout;
    logic cold;
    logic hot;
    logic slope_negative;
    logic adc_in_window;
  } cstc_flags_t;

  // Decoded configuration
  typedef struct packed {
    logic [4:0] cell_count;
    logic [1:0] range_idx;
    logic long_timeout;
    logic slope_enable;
  } cstc_config_t;

endpackage

// ===== tb/cstc_charge_ctrl_sva.sv
// Purpose: Port assertions for the charge state timer control
// Assumes: Flags held several cycles; 2-flop sync then state register
// Notes: Margins of two cycles cover the sync stage
`timescale 1ns/10ps
module cstc_charge_ctrl_sva #(
  parameter longint unsigned SAMPLE_CYCLES = 7,
  parameter longint unsigned MINUTE_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs
  input wire cstc_pkg::cstc_straps_t straps,
  input wire cstc_pkg::cstc_flags_t flags,
  // Outputs
  input wire logic fast_state_status_out_oe_n,
  input wire logic fast_state,
  input wire cstc_pkg::cstc_config_t config_out,
  input wire logic timer_expired,
  input wire logic slope_detected
);
  logic [31:0] fast_cnt_reg;
  logic [31:0] fast_cnt_next;
  logic ok;
  assign ok = flags.power_on_hold_n & flags.cell_above_lockout & ~flags.cold & ~flags.hot;
  always_comb begin
    fast_cnt_next = fast_state ? fast_cnt_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    fast_cnt_reg <= sys_rst ? 32'h0 : fast_cnt_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  status_sink_a: assert property (fast_state_status_out_oe_n == !fast_state)
    else $error("status pin disagrees with state");
  hold_trickle_a: assert property (!flags.power_on_hold_n [*3] |=> !fast_state)
    else $error("fast while hold low");
  hot_revert_a: assert property (flags.hot [*3] |=> !fast_state)
    else $error("fast while hot");
  cold_hold_a: assert property ((!fast_state throughout flags.cold [*4]) |=> !fast_state)
    else $error("fast entered while cold");
  lockout_hold_a: assert property
    ((!fast_state throughout !flags.cell_above_lockout [*4]) |=> !fast_state)
    else $error("fast entered below lockout");
  fast_entry_a: assert property (!flags.power_on_hold_n [*3] ##1 ok [*3] |=> fast_state)
    else $error("no fast after hold release");
  expiry_end_a: assert property ($rose(timer_expired) |=> !fast_state)
    else $error("fast after expiry");
  slope_end_a: assert property
    ($rose(slope_detected) |-> config_out.slope_enable ##1 !fast_state)
    else $error("slope end wrong");
  timer_span_a: assert property ($rose(timer_expired) |->
    fast_cnt_reg + 2 >= 22 * MINUTE_CYCLES && fast_cnt_reg <= 264 * MINUTE_CYCLES + 2)
    else $error("timeout outside span");
  cell_decode_a: assert property ($rose(fast_state) |-> config_out.cell_count ==
    {1'b0, straps.cell_count_strap_major, straps.cell_count_strap_minor} + 5'h01)
    else $error("cell count decode");
endmodule // cstc_charge_ctrl_sva

bind cstc_charge_ctrl cstc_charge_ctrl_sva #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .MINUTE_CYCLES(MINUTE_CYCLES)
) u_sva (.clk(clk), .sys_rst(sys_rst), .straps(straps), .flags(flags),
  .fast_state_status_out_oe_n(fast_state_status_out_oe_n), .fast_state(fast_state),
  .config_out(config_out), .timer_expired(timer_expired), .slope_detected(slope_detected));

// ===== tb/cstc_pack_model.sv
// Purpose: Pack, thermistor and regulator stand-in driving the flags
// Assumes: Bench changes conditions at falling edges
// Notes: Cold and hot are never both set
`timescale 1ns/10ps
module cstc_pack_model (
  // Conditions
  input wire logic supply_on,
  input wire logic [1:0] temp_zone,
  input wire logic cells_ok,
  input wire logic full,
  input wire logic in_window,
  // Flags
  output cstc_pkg::cstc_flags_t flags
);
  // Zone 0 safe, 1 cold, 2 hot
  always_comb begin
    flags.power_on_hold_n = supply_on;
    flags.cold = temp_zone == 2'h1;
    flags.hot = temp_zone == 2'h2;
    flags.cell_above_lockout = cells_ok;
    flags.adc_in_window = in_window;
    flags.slope_negative = full;
  end
endmodule // cstc_pack_model

// ===== tb/tb_cstc_charge_ctrl.sv
// Purpose: Self-checking bench for the charge state timer control
// Assumes: Minute is 10 cycles, sample step 7 cycles
// Notes: Straps only change while hold is low
`timescale 1ns/10ps
module tb_cstc_charge_ctrl;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwr = 1'b0;
  logic [1:0] zone = 2'h0;
  logic cok = 1'b0;
  logic full = 1'b0;
  logic win = 1'b1;
  cstc_pkg::cstc_straps_t straps = 8'h00;
  cstc_pkg::cstc_flags_t flags;
  logic oe_n, fast, te, sd;
  cstc_pkg::cstc_config_t cfg;
  int fails = 0;
  int compares = 0;
  always #2 clk = ~clk;
  cstc_pack_model pack (.supply_on(pwr), .temp_zone(zone), .cells_ok(cok), .full(full),
    .in_window(win), .flags(flags));
  cstc_charge_ctrl #(.SAMPLE_CYCLES(7), .MINUTE_CYCLES(10)) dut (.clk(clk), .sys_rst(sys_rst),
    .straps(straps), .flags(flags), .fast_state_status_out_oe_n(oe_n), .fast_state(fast),
    .config_out(cfg), .timer_expired(te), .slope_detected(sd));
  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic pwr_up(input logic [7:0] s, input logic [1:0] z, input logic ok);
    @(negedge clk);
    pwr = 1'b0;
    straps = s;
    zone = z;
    cok = ok;
    full = 1'b0;
    repeat (4) @(negedge clk);
    pwr = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic run_out(input int lim, output int n, output logic t, output logic s);
    n = 0; t = 1'b0; s = 1'b0;
    while (fast === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
      t |= te;
      s |= sd;
    end
  endtask
  task automatic sc_decode();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      pwr_up({k, k[1:0], k[3:2]}, 2'h0, 1'b0);
      chk(cfg.cell_count === 5'(k) + 5'h01, "cell count");
      chk(cfg.range_idx === k[3:2], "range index");
      chk(cfg.long_timeout === (k[1:0] == 2'h0 || k[1:0] == 2'h3), "long");
      chk(cfg.slope_enable === k[1], "slope enable");
      chk(fast === 1'b0 && oe_n === 1'b1, "fast below lockout");
    end
    cok = 1'b1;
    repeat (6) @(negedge clk);
    chk(fast === 1'b0, "late lockout start");
  endtask
  task automatic sc_timer(input logic [3:0] s, input int mins);
    int n;
    logic t, d;
    pwr_up({4'h0, s}, 2'h0, 1'b1);
    chk(fast === 1'b1 && oe_n === 1'b0, "no fast entry");
    full = 1'b1;
    run_out(mins * 10 + 40, n, t, d);
    chk(n >= mins * 10 - 6 && n <= mins * 10 + 2, "timeout length");
    chk(t === 1'b1 && fast === 1'b0, "expiry");
    chk(d === 1'b0, "slope while disabled");
  endtask
  task automatic sc_slope();
    int n;
    logic t, d;
    pwr_up(8'h0C, 2'h0, 1'b1);
    win = 1'b0;
    full = 1'b1;
    run_out(40, n, t, d);
    chk(d === 1'b0 && fast === 1'b1, "slope outside window");
    win = 1'b1;
    run_out(40, n, t, d);
    chk(d === 1'b1 && fast === 1'b0, "slope end");
    chk(t === 1'b0, "timer during slope");
  endtask
  task automatic sc_hot();
    pwr_up(8'h03, 2'h0, 1'b1);
    zone = 2'h2;
    repeat (4) @(negedge clk);
    chk(fast === 1'b0, "hot end");
    zone = 2'h0;
    repeat (6) @(negedge clk);
    chk(fast === 1'b0, "restart after hot");
    pwr_up(8'h03, 2'h2, 1'b1);
    zone = 2'h0;
    repeat (6) @(negedge clk);
    chk(fast === 1'b0, "hot at power-up");
    pwr_up(8'h03, 2'h0, 1'b1);
    chk(fast === 1'b1, "after supply cycle");
  endtask
  task automatic sc_cold();
    pwr_up(8'h03, 2'h1, 1'b1);
    chk(fast === 1'b0, "cold start");
    zone = 2'h0;
    repeat (5) @(negedge clk);
    chk(fast === 1'b1, "warm-up entry");
    pwr = 1'b0;
    repeat (4) @(negedge clk);
    chk(fast === 1'b0 && oe_n === 1'b1, "hold low");
  endtask
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    sc_decode();
    sc_timer(4'h4, 22);
    sc_timer(4'h3, 264);
    sc_slope();
    sc_hot();
    sc_cold();
    summarize();
  end
endmodule // tb_cstc_charge_ctrl
